/* pkg/ssn_cfg.svh */
// Constants for the synchronous transfer negotiation block.
// Assumes inclusion by bare name from design files.
`ifndef SSN_CFG_SVH
`define SSN_CFG_SVH

`define SSN_EXT_MSG_CODE    8'h01
`define SSN_EXT_MSG_LEN     8'h03
`define SSN_SDTR_CODE       8'h01
`define SSN_REJECT_CODE     8'h07
`define SSN_MSG_BYTES       3'h5
`define SSN_PERIOD_MIN      8'h3E
`define SSN_PERIOD_MAX      8'hFF
`define SSN_OFFSET_MAX      8'h08
`define SSN_OFFSET_ASYNC    8'h00
`define SSN_OFFSET_UNLIM    8'hFF
`define SSN_PERIOD_UNIT_NS  4
`define SSN_CLK_PERIOD_NS   20
`define SSN_RST_PERIOD      8'h00
`define SSN_RST_OFFSET      8'h00

`endif

/* pkg/ssn_pkg.sv */
// Types for the synchronous transfer negotiation block.
// Assumes ssn_cfg.svh supplies the numeric constants.
package ssn_pkg;

  typedef enum logic [2:0] {
    SSN_IDLE    = 3'b000,
    SSN_RX      = 3'b001,
    SSN_TX      = 3'b010,
    SSN_WAIT    = 3'b011,
    SSN_REJWAIT = 3'b100
  } ssn_state_t;

endpackage

/* design/ssn_msg_gen.sv */
// Message byte generator for the negotiation block.
// Assumes byte index is sequenced by the caller on the same clock.
`timescale 1ns/100ps
`include "ssn_cfg.svh"

module ssn_msg_gen (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [2:0] idx,
  input  wire logic [7:0] period,
  input  wire logic [7:0] offset,
  output logic      [7:0] byte_out
);

  logic [7:0] byte_d;
  logic [7:0] byte_q;

  // Five-byte extended message layout
  always_comb begin
    case (idx)
      3'h0:    byte_d = `SSN_EXT_MSG_CODE;
      3'h1:    byte_d = `SSN_EXT_MSG_LEN;
      3'h2:    byte_d = `SSN_SDTR_CODE;
      3'h3:    byte_d = period;
      3'h4:    byte_d = offset;
      default: byte_d = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      byte_q <= 8'h00;
    end else begin
      byte_q <= byte_d;
    end
  end

  assign byte_out = byte_q;

endmodule

/* design/ssn_pace.sv */
// Data-phase REQ pacing: spacing and outstanding offset limit.
// Assumes ack_edge is a one-cycle pulse on ref_clk.
`timescale 1ns/100ps
`include "ssn_cfg.svh"

module ssn_pace #(
  parameter int CW = 12
) (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          sync_mode,
  input  wire logic [7:0]    period,
  input  wire logic [7:0]    offset,
  input  wire logic          req_pulse,
  input  wire logic          ack_edge,
  output logic               req_ok
);

  logic [CW-1:0] gap_d;
  logic [CW-1:0] gap_q;
  logic [8:0]    outst_d;
  logic [8:0]    outst_q;
  logic [CW-1:0] gap_cycles;
  logic          unlim;
  logic          ok_d;
  logic          ok_q;

  // Period factor times four ns, rounded up to cycles
  assign gap_cycles = CW'(((32'(period) * `SSN_PERIOD_UNIT_NS)
                      + `SSN_CLK_PERIOD_NS - 1) / `SSN_CLK_PERIOD_NS);
  assign unlim = (offset == `SSN_OFFSET_UNLIM);

  always_comb begin
    gap_d   = gap_q;
    outst_d = outst_q;
    if (gap_q != '0) begin
      gap_d = gap_q - CW'(1);
    end
    if (req_pulse) begin
      gap_d = gap_cycles;
    end
    if (!sync_mode) begin
      outst_d = 9'h000;
    end else begin
      case ({req_pulse, ack_edge && (outst_q != 9'h000)})
        2'b10:   outst_d = outst_q + 9'h001;
        2'b01:   outst_d = outst_q - 9'h001;
        default: outst_d = outst_q;
      endcase
    end
    // Async: gap only, ACKs not counted; sync: bounded by offset
    if (!sync_mode) begin
      ok_d = (gap_d == '0) && !req_pulse;
    end else begin
      ok_d = (gap_d <= CW'(1)) &&
             (unlim || (outst_d < {1'b0, offset}));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gap_q   <= '0;
      outst_q <= 9'h000;
      ok_q    <= 1'b0;
    end else begin
      gap_q   <= gap_d;
      outst_q <= outst_d;
      ok_q    <= ok_d;
    end
  end

  assign req_ok = ok_q;

endmodule

/* design/ssn_negotiator.sv */
// Synchronous transfer negotiation for the scanner target.
// Assumes message bytes arrive as same-clock strobes from the phase
// engine, which also supplies originate, reject and reset indications.
`timescale 1ns/100ps
`include "ssn_cfg.svh"

module ssn_negotiator #(
  parameter logic [7:0] OWN_PERIOD = `SSN_PERIOD_MIN,
  parameter logic [7:0] OWN_OFFSET = `SSN_OFFSET_MAX,
  parameter int         CW         = 12
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       bdr_msg,
  input  wire logic       originate,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_byte,
  input  wire logic       rx_reject,
  input  wire logic       tx_ack,
  input  wire logic       data_phase,
  input  wire logic       req_pulse,
  input  wire logic       ack_edge,
  output logic            tx_valid,
  output logic      [7:0] tx_byte,
  output logic            go_bus_free,
  output logic            neg_pending,
  output logic            sync_mode,
  output logic      [7:0] agreed_period,
  output logic      [7:0] agreed_offset,
  output logic            req_ok
);

  ssn_pkg::ssn_state_t st_d;
  ssn_pkg::ssn_state_t st_q;
  logic [2:0] rx_idx_d;
  logic [2:0] rx_idx_q;
  logic [2:0] tx_idx_d;
  logic [2:0] tx_idx_q;
  logic [7:0] peer_per_d;
  logic [7:0] peer_per_q;
  logic [7:0] peer_off_d;
  logic [7:0] peer_off_q;
  logic [7:0] out_per_d;
  logic [7:0] out_per_q;
  logic [7:0] out_off_d;
  logic [7:0] out_off_q;
  logic       orig_d;
  logic       orig_q;
  logic       pend_d;
  logic       pend_q;
  logic       sync_d;
  logic       sync_q;
  logic [7:0] per_d;
  logic [7:0] per_q;
  logic [7:0] off_d;
  logic [7:0] off_q;
  logic       txv_d;
  logic       txv_q;
  logic       bf_d;
  logic       bf_q;
  logic       hdr_ok;
  logic [7:0] fit_per;
  logic [7:0] fit_off;
  logic [7:0] gen_byte;
  logic       pace_ok;
  logic [7:0] own_per_c;
  logic [7:0] own_off_c;
  logic       rx_done;
  logic       tx_last;
  logic       pace_sync;

  // Own limits clamped into the supported ranges
  assign own_per_c = (OWN_PERIOD < `SSN_PERIOD_MIN) ? `SSN_PERIOD_MIN
                                                     : OWN_PERIOD;
  assign own_off_c = (OWN_OFFSET > `SSN_OFFSET_MAX) ? `SSN_OFFSET_MAX
                                                     : OWN_OFFSET;

  // Longer period and smaller offset substituted only when needed
  assign fit_per = (peer_per_q < own_per_c) ? own_per_c : peer_per_q;
  assign fit_off = (peer_off_q > own_off_c) ? own_off_c : peer_off_q;

  // Whole message in, or the last byte of ours on its way out
  assign rx_done = (rx_idx_q == `SSN_MSG_BYTES);
  assign tx_last = (tx_idx_q == `SSN_MSG_BYTES - 3'h1);

  // Pacing follows the agreement in data phases only
  assign pace_sync = sync_q && data_phase;

  // Bytes 0 to 2 must carry the fixed codes
  always_comb begin
    case (rx_idx_q)
      3'h0:    hdr_ok = (rx_byte == `SSN_EXT_MSG_CODE);
      3'h1:    hdr_ok = (rx_byte == `SSN_EXT_MSG_LEN);
      3'h2:    hdr_ok = (rx_byte == `SSN_SDTR_CODE);
      default: hdr_ok = 1'b1;
    endcase
  end

  always_comb begin
    st_d       = st_q;
    rx_idx_d   = rx_idx_q;
    tx_idx_d   = tx_idx_q;
    peer_per_d = peer_per_q;
    peer_off_d = peer_off_q;
    out_per_d  = out_per_q;
    out_off_d  = out_off_q;
    orig_d     = orig_q;
    pend_d     = pend_q;
    sync_d     = sync_q;
    per_d      = per_q;
    off_d      = off_q;
    txv_d      = txv_q;
    bf_d       = 1'b0;
    case (st_q)
      ssn_pkg::SSN_IDLE: begin
        if (rx_valid) begin
          // First byte is checked here so counting resumes at the length
          if (rx_byte == `SSN_EXT_MSG_CODE) begin
            rx_idx_d = 3'h1;
            orig_d   = 1'b0;
            st_d     = ssn_pkg::SSN_RX;
          end
        end else if (pend_q) begin
          // Propose what we can receive reliably
          out_per_d = own_per_c;
          out_off_d = own_off_c;
          orig_d    = 1'b1;
          tx_idx_d  = 3'h0;
          txv_d     = 1'b1;
          st_d      = ssn_pkg::SSN_TX;
        end
      end
      ssn_pkg::SSN_RX: begin
        if (rx_valid) begin
          // A wrong header byte drops the message without a reply
          if (!hdr_ok) begin
            st_d = ssn_pkg::SSN_IDLE;
          end else begin
            if (rx_idx_q == 3'h3) begin
              peer_per_d = rx_byte;
            end
            if (rx_idx_q == 3'h4) begin
              peer_off_d = rx_byte;
            end
            rx_idx_d = rx_idx_q + 3'h1;
          end
        end else if (rx_done) begin
          if (orig_q) begin
            // Reply closes our exchange
            per_d  = fit_per;
            off_d  = fit_off;
            sync_d = (peer_off_q != `SSN_OFFSET_ASYNC);
            pend_d = 1'b0;
            st_d   = ssn_pkg::SSN_IDLE;
          end else begin
            // Answer with the message, never a reject
            out_per_d = fit_per;
            out_off_d = fit_off;
            tx_idx_d  = 3'h0;
            txv_d     = 1'b1;
            st_d      = ssn_pkg::SSN_TX;
          end
        end
      end
      ssn_pkg::SSN_TX: begin
        if (tx_ack) begin
          if (tx_last) begin
            txv_d = 1'b0;
            if (orig_q) begin
              rx_idx_d = 3'h0;
              st_d     = ssn_pkg::SSN_WAIT;
            end else begin
              per_d  = out_per_q;
              off_d  = out_off_q;
              sync_d = (out_off_q != `SSN_OFFSET_ASYNC);
              pend_d = 1'b0;
              st_d   = ssn_pkg::SSN_IDLE;
            end
          end else begin
            // Each accepted byte moves on to the next one
            tx_idx_d = tx_idx_q + 3'h1;
          end
        end
      end
      ssn_pkg::SSN_WAIT: begin
        if (rx_reject) begin
          sync_d = 1'b0;
          off_d  = `SSN_OFFSET_ASYNC;
          pend_d = 1'b0;
          st_d   = ssn_pkg::SSN_IDLE;
        end else if (rx_valid) begin
          st_d = ssn_pkg::SSN_RX;
          if (rx_byte == `SSN_EXT_MSG_CODE) begin
            rx_idx_d = 3'h1;
          end else begin
            st_d = ssn_pkg::SSN_IDLE;
          end
        end
      end
      default: st_d = ssn_pkg::SSN_IDLE;
    endcase
    // A new request outlives a clear in the same cycle
    if (originate) begin
      pend_d = 1'b1;
    end
    // Device reset message voids the agreement
    if (bdr_msg) begin
      st_d   = ssn_pkg::SSN_IDLE;
      sync_d = 1'b0;
      per_d  = `SSN_RST_PERIOD;
      off_d  = `SSN_RST_OFFSET;
      pend_d = 1'b1;
      txv_d  = 1'b0;
      bf_d   = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q       <= ssn_pkg::SSN_IDLE;
      rx_idx_q   <= 3'h0;
      tx_idx_q   <= 3'h0;
      peer_per_q <= `SSN_RST_PERIOD;
      peer_off_q <= `SSN_RST_OFFSET;
      out_per_q  <= `SSN_RST_PERIOD;
      out_off_q  <= `SSN_RST_OFFSET;
      orig_q     <= 1'b0;
      pend_q     <= 1'b1;
      sync_q     <= 1'b0;
      per_q      <= `SSN_RST_PERIOD;
      off_q      <= `SSN_RST_OFFSET;
      txv_q      <= 1'b0;
      bf_q       <= 1'b0;
    end else begin
      st_q       <= st_d;
      rx_idx_q   <= rx_idx_d;
      tx_idx_q   <= tx_idx_d;
      peer_per_q <= peer_per_d;
      peer_off_q <= peer_off_d;
      out_per_q  <= out_per_d;
      out_off_q  <= out_off_d;
      orig_q     <= orig_d;
      pend_q     <= pend_d;
      sync_q     <= sync_d;
      per_q      <= per_d;
      off_q      <= off_d;
      txv_q      <= txv_d;
      bf_q       <= bf_d;
    end
  end

  // Next byte is registered so it lines up with tx_valid
  ssn_msg_gen u_gen (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .idx      (tx_idx_d),
    .period   (out_per_d),
    .offset   (out_off_d),
    .byte_out (gen_byte)
  );

  // Agreed pacing applies in data phases only; async rules otherwise
  ssn_pace #(
    .CW (CW)
  ) u_pace (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .sync_mode (pace_sync),
    .period    (per_q),
    .offset    (off_q),
    .req_pulse (req_pulse),
    .ack_edge  (ack_edge),
    .req_ok    (pace_ok)
  );

  assign tx_valid      = txv_q;
  assign tx_byte       = gen_byte;
  assign go_bus_free   = bf_q;
  assign neg_pending   = pend_q;
  assign sync_mode     = sync_q;
  assign agreed_period = per_q;
  assign agreed_offset = off_q;
  assign req_ok        = pace_ok;

endmodule

/* dv/ssn_negotiator_properties.sv */
// Checker for the negotiation block, bound to ssn_negotiator.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
module ssn_neg_props (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       bdr_msg,
  input wire logic       rx_reject,
  input wire logic       tx_ack,
  input wire logic       data_phase,
  input wire logic       req_pulse,
  input wire logic       ack_edge,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic       go_bus_free,
  input wire logic       neg_pending,
  input wire logic       sync_mode,
  input wire logic [7:0] agreed_period,
  input wire logic [7:0] agreed_offset,
  input wire logic       req_ok
);
  logic [7:0]  gap_q, gap_d, outs_q, outs_d;
  logic [10:0] need;
  logic        sdp;
  // Cycles since the last REQ and REQs still awaiting ACK
  always_comb begin
    gap_d  = req_pulse ? 8'h01 : gap_q + {7'h00, gap_q != 8'hFF};
    outs_d = outs_q + {7'h00, req_pulse} - {7'h00, ack_edge};
    need   = ({3'h0, agreed_period} * 11'h004 + 11'h013) / 11'h014;
    sdp    = sync_mode && data_phase;
  end
  always_ff @(posedge ref_clk) begin
    gap_q  <= rst ? 8'hFF : gap_d;
    outs_q <= rst ? 8'h00 : outs_d;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_bus_free: assert property (bdr_msg |=> go_bus_free)
    else $error("no bus free after device reset");
  chk_bdr_async: assert property (bdr_msg |-> ##[1:2] !sync_mode)
    else $error("agreement kept after device reset");
  chk_reset_async: assert property ($fell(rst) |-> !sync_mode &&
    neg_pending && agreed_offset == 8'h00 && !tx_valid)
    else $error("bad state after reset");
  chk_offset_range: assert property (sync_mode |->
    agreed_offset inside {[8'h01:8'h08]})
    else $error("sync with offset out of range");
  chk_period_range: assert property (sync_mode |->
    agreed_period >= 8'h3E)
    else $error("sync with period below minimum");
  chk_reject_async: assert property (rx_reject |-> ##[1:2] !sync_mode)
    else $error("sync kept after reject");
  chk_tx_hold: assert property (tx_valid && !tx_ack |=>
    tx_valid && $stable(tx_byte))
    else $error("tx byte changed before ack");
  chk_tx_header: assert property ($rose(tx_valid) |->
    tx_byte == 8'h01)
    else $error("message does not open with 01");
  chk_req_gap: assert property (req_ok && sdp |->
    {3'h0, gap_q} >= need)
    else $error("REQ allowed too early");
  chk_req_limit: assert property (req_ok |->
    outs_q < (sdp ? agreed_offset : 8'h01))
    else $error("REQ allowed beyond offset");
  cover property (rx_reject ##1 !sync_mode);
  cover property ($rose(sync_mode));
  cover property (bdr_msg ##1 go_bus_free);
  cover property (req_ok && sdp && outs_q == 8'h03);
endmodule

bind ssn_negotiator ssn_neg_props u_props (
  .ref_clk(ref_clk), .rst(rst), .bdr_msg(bdr_msg), .rx_reject(rx_reject),
  .tx_ack(tx_ack), .data_phase(data_phase), .req_pulse(req_pulse),
  .ack_edge(ack_edge), .tx_valid(tx_valid), .tx_byte(tx_byte),
  .go_bus_free(go_bus_free), .neg_pending(neg_pending),
  .sync_mode(sync_mode), .agreed_period(agreed_period),
  .agreed_offset(agreed_offset), .req_ok(req_ok)
);

/* dv/ssn_host_model.sv */
// Host initiator stand-in: sends message bytes, takes reply bytes.
// Assumes the block samples on rising ref_clk; drives on the falling one.
`timescale 1ns/100ps
`include "ssn_cfg.svh"
module ssn_host_model (
  input  wire logic       ref_clk,
  input  wire logic       slow,
  input  wire logic       tx_valid,
  output logic            rx_valid,
  output logic      [7:0] rx_byte,
  output logic            tx_ack
);
  int w;
  initial begin
    rx_valid = 1'b0;
    rx_byte  = 8'h5A;
    tx_ack   = 1'b0;
    w        = 0;
  end
  // Address probing and inquiry filtering stay in host start-up code;
  // this stand-in talks to one target at unit 0 only
  // One ack pulse per byte, promptly or after a wait
  always @(negedge ref_clk) begin
    if (tx_ack) begin
      tx_ack = 1'b0;
      w      = 0;
    end else if (tx_valid === 1'b1) begin
      if (w >= (slow ? 3 : 0)) tx_ack = 1'b1;
      else w++;
    end
  end
  task automatic send(input logic [7:0] p, input logic [7:0] o);
    logic [7:0] m [5];
    m = '{`SSN_EXT_MSG_CODE, `SSN_EXT_MSG_LEN, `SSN_SDTR_CODE, p, o};
    for (int i = 0; i < 5; i++) begin
      @(negedge ref_clk);
      rx_valid = 1'b1;
      rx_byte  = m[i];
    end
    @(negedge ref_clk);
    rx_valid = 1'b0;
    // Released lines show no stale byte
    rx_byte  = ~rx_byte;
  endtask
endmodule

/* dv/ssn_negotiator_tb_top.sv */
// Testbench for ssn_negotiator with a host model on the message side.
// Assumes a 50 MHz clock and inputs driven on the falling edge.
`timescale 1ns/100ps
`include "ssn_cfg.svh"
`define SSN_CHK(n, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) begin \
      fails++; \
      $display("BAD %s exp %0h got %0h", n, e, g); \
    end \
  end
module ssn_negotiator_tb_top;
  logic        ref_clk, rst, bdr_msg, originate, rx_reject, data_phase;
  logic        req_pulse, ack_edge, slow, tx_ack, rx_valid, tx_valid;
  logic        go_bus_free, neg_pending, sync_mode, req_ok;
  logic [7:0]  rx_byte, tx_byte, agreed_period, agreed_offset, e;
  logic [7:0]  exp_q [$];
  logic [15:0] tab [5];
  logic [31:0] rs;
  int          fails, check_count, nreq;
  ssn_negotiator u_dut (
    .ref_clk(ref_clk), .rst(rst), .bdr_msg(bdr_msg),
    .originate(originate), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_reject(rx_reject), .tx_ack(tx_ack), .data_phase(data_phase),
    .req_pulse(req_pulse), .ack_edge(ack_edge), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .go_bus_free(go_bus_free),
    .neg_pending(neg_pending), .sync_mode(sync_mode),
    .agreed_period(agreed_period), .agreed_offset(agreed_offset),
    .req_ok(req_ok)
  );
  ssn_host_model u_host (
    .ref_clk(ref_clk), .slow(slow), .tx_valid(tx_valid),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_ack(tx_ack)
  );
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  task automatic note(input logic [7:0] p, input logic [7:0] o);
    exp_q.push_back(`SSN_EXT_MSG_CODE);
    exp_q.push_back(`SSN_EXT_MSG_LEN);
    exp_q.push_back(`SSN_SDTR_CODE);
    exp_q.push_back(p);
    exp_q.push_back(o);
  endtask
  task automatic wait_tx();
    int n;
    n = 0;
    while (tx_valid !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    while (tx_valid === 1'b1 && n < 600) begin
      @(negedge ref_clk);
      n++;
    end
    `SSN_CHK("tx_end", 1'b1, n < 200)
  endtask
  task automatic agree(input logic [7:0] p, input logic [7:0] o);
    repeat (2) @(negedge ref_clk);
    `SSN_CHK("sync_mode", o != 8'h00, sync_mode)
    if (o != 8'h00) begin
      `SSN_CHK("agreed_period", p, agreed_period)
      `SSN_CHK("agreed_offset", o, agreed_offset)
    end
  endtask
  task automatic xchg(input logic [7:0] p, input logic [7:0] o);
    logic [7:0] ep, eo;
    ep = (p < `SSN_PERIOD_MIN) ? `SSN_PERIOD_MIN : p;
    eo = (o > `SSN_OFFSET_MAX) ? `SSN_OFFSET_MAX : o;
    note(ep, eo);
    u_host.send(p, o);
    wait_tx();
    agree(ep, eo);
  endtask
  task automatic pace(input int n);
    repeat (n) begin
      @(negedge ref_clk);
      req_pulse = (req_ok === 1'b1);
      nreq += req_pulse;
    end
    @(negedge ref_clk);
    req_pulse = 1'b0;
  endtask
  task automatic ack(input int n);
    repeat (n) begin
      ack_edge = 1'b1;
      @(negedge ref_clk);
      ack_edge = 1'b0;
      @(negedge ref_clk);
    end
  endtask
  task automatic summarize();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Each message byte taken by the host is matched to the oldest note
  always @(posedge ref_clk) begin
    if (tx_valid === 1'b1 && tx_ack === 1'b1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX;
      `SSN_CHK("tx_byte", e, tx_byte)
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    #400000;
    fails++;
    $display("BAD watchdog exp done got hang");
    summarize();
  end
  initial begin
    {rst, bdr_msg, originate, rx_reject} = 4'hF;
    {bdr_msg, originate, rx_reject, data_phase} = 4'h0;
    {req_pulse, ack_edge, slow} = 3'h0;
    tab = '{16'h3DFF, 16'h3E00, 16'hFF09, 16'h8003, 16'h6404};
    rs = 32'h2B;
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    `SSN_CHK("neg_pending", 1'b1, neg_pending)
    `SSN_CHK("sync_mode", 1'b0, sync_mode)
    note(`SSN_PERIOD_MIN, `SSN_OFFSET_MAX);
    slow = 1'b1;
    wait_tx();
    u_host.send(8'h64, 8'h04);
    agree(8'h64, 8'h04);
    for (int i = 0; i < 8; i++) begin
      slow = i[0];
      rs = xs(rs);
      if (i < 3) xchg(rs[7:0], rs[11:8] > 4'h8 ? 8'hFF : {4'h0, rs[11:8]});
      else xchg(tab[i-3][15:8], tab[i-3][7:0]);
    end
    data_phase = 1'b1;
    nreq = 0;
    pace(120);
    `SSN_CHK("req_count", 4, nreq)
    ack(1);
    pace(40);
    `SSN_CHK("req_count", 5, nreq)
    ack(4);
    data_phase = 1'b0;
    note(`SSN_PERIOD_MIN, `SSN_OFFSET_MAX);
    originate = 1'b1;
    @(negedge ref_clk);
    originate = 1'b0;
    wait_tx();
    rx_reject = 1'b1;
    @(negedge ref_clk);
    rx_reject = 1'b0;
    agree(8'h00, 8'h00);
    xchg(8'h64, 8'h04);
    note(`SSN_PERIOD_MIN, `SSN_OFFSET_MAX);
    bdr_msg = 1'b1;
    @(negedge ref_clk);
    bdr_msg = 1'b0;
    `SSN_CHK("go_bus_free", 1'b1, go_bus_free)
    wait_tx();
    `SSN_CHK("sync_mode", 1'b0, sync_mode)
    u_host.send(8'h3E, 8'h00);
    agree(8'h3E, 8'h00);
    `SSN_CHK("notes_left", 0, exp_q.size())
    summarize();
  end
endmodule
